// File: tb.sv
// Self-checking bench for the power-state control block.
// Assumes the controller model of its own file; one 100 MHz clock.
`timescale 1ns/100ps
module tb;
  logic clk, rst_n, pll_sleep, ref_input_sleep_n;
  logic [1:0][1:0] want_state;
  logic [1:0] want_idle, want_detect, rx_present;
  logic [1:0] tx_power_state_0, tx_power_state_1;
  logic [1:0] rx_power_state_0, rx_power_state_1;
  logic [1:0] tx_idle_request, rx_detect_request;
  logic [11:0] leave_deep_count;
  logic [7:0] shallow_transition_count;
  logic [9:0] enter_deep_count;
  logic [4:0] tick_divider;
  logic pll_lock_flag, pll_running, ref_input_running, ref_forward_en;
  logic [1:0] phy_ack_pulse, tx_active, tx_beacon, loopback;
  logic [2:0] detect_result_0, detect_result_1;
  logic [1:0] tx_state_now_0, tx_state_now_1, rx_state_now_0, rx_state_now_1;
  int fail_count, n_compared;
  tpsc_top dut (.clk, .rst_n, .pll_sleep, .ref_input_sleep_n,
    .tx_power_state_0, .tx_power_state_1, .rx_power_state_0,
    .rx_power_state_1, .tx_idle_request, .rx_detect_request, .rx_present,
    .leave_deep_count, .shallow_transition_count, .enter_deep_count,
    .tick_divider, .pll_lock_flag, .pll_running, .ref_input_running,
    .ref_forward_en, .phy_ack_pulse, .detect_result_0, .detect_result_1,
    .tx_state_now_0, .tx_state_now_1, .rx_state_now_0, .rx_state_now_1,
    .tx_active, .tx_beacon, .loopback);
  tpsc_mac_model m0 (.want_state(want_state[0]), .want_idle(want_idle[0]),
    .want_detect(want_detect[0]), .tx_power_state(tx_power_state_0),
    .rx_power_state(rx_power_state_0), .tx_idle_request(tx_idle_request[0]),
    .rx_detect_request(rx_detect_request[0]));
  tpsc_mac_model m1 (.want_state(want_state[1]), .want_idle(want_idle[1]),
    .want_detect(want_detect[1]), .tx_power_state(tx_power_state_1),
    .rx_power_state(rx_power_state_1), .tx_idle_request(tx_idle_request[1]),
    .rx_detect_request(rx_detect_request[1]));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp,
      input string what);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Count zero still waits one tick
  function automatic int exp_ticks(input logic [1:0] from, input logic [1:0] to);
    int t;
    t = from == 2'h3 ? leave_deep_count :
      (to == 2'h3 ? enter_deep_count : shallow_transition_count);
    return t == 0 ? 1 : t;
  endfunction
  task automatic wait_ack(input int ch, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (phy_ack_pulse[ch] !== 1'b1 && n < lim);
    if (phy_ack_pulse[ch] !== 1'b1) begin
      check(0, 1, "no acknowledge");
      give_verdict();
    end
  endtask
  task automatic wait_lock();
    int n;
    n = 0;
    while (pll_lock_flag !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(pll_lock_flag, 1, "lock");
    if (n >= 300) give_verdict();
  endtask
  task automatic move(input int ch, input logic [1:0] s, input logic idl);
    int lo, n;
    // Same code twice is never acknowledged; step away first
    if (want_state[ch] == s) move(ch, ~s, idl);
    lo = exp_ticks(want_state[ch], s) * tick_divider;
    @(negedge clk);
    want_state[ch] = s;
    want_idle[ch] = idl;
    wait_ack(ch, lo + 4 * tick_divider + 30, n);
    check(n >= lo, 1, "acknowledge early");
    check(n <= lo + 2 * tick_divider + 12, 1, "acknowledge late");
    @(posedge clk);
    #1;
    check(phy_ack_pulse[ch], 0, "acknowledge width");
    check(phy_ack_pulse[1 - ch], 0, "other channel");
    repeat (2) @(posedge clk);
    #1;
    check(ch ? tx_state_now_1 : tx_state_now_0, s, "tx state");
    check(ch ? rx_state_now_1 : rx_state_now_0, s, "rx state");
  endtask
  task automatic lv(input int ch);
    logic [1:0] s;
    logic i, d;
    repeat (8) @(posedge clk);
    #1;
    s = want_state[ch];
    i = tx_idle_request[ch];
    d = rx_detect_request[ch];
    check(tx_beacon[ch], s == 2'h3 && !i, "beacon");
    check(loopback[ch], s == 2'h0 && d && !i, "loopback");
    if (!d) check(tx_active[ch], s == 2'h0 && !i, "active");
  endtask
  initial begin
    int n;
    rst_n = 1'b0;
    pll_sleep = 1'b0;
    ref_input_sleep_n = 1'b1;
    want_state = 4'hF;
    want_idle = 2'h3;
    want_detect = 2'h0;
    rx_present = 2'h0;
    void'($urandom(32'h9285));
    tick_divider = 5'(2 + $urandom % 3);
    leave_deep_count = 12'($urandom % 16);
    shallow_transition_count = 8'h00;
    enter_deep_count = 10'($urandom % 16);
    repeat (4) @(negedge clk);
    check(tx_state_now_0, 2'h3, "reset state");
    check(phy_ack_pulse, 2'h0, "reset acknowledge");
    rst_n = 1'b1;
    wait_lock();
    // Two-code use: idle follows the state code
    for (int ch = 0; ch < 2; ch++) begin
      move(ch, 2'h0, 1'b0);
      lv(ch);
      move(ch, 2'h3, 1'b1);
      lv(ch);
    end
    $display("test two_codes done");
    shallow_transition_count = 8'($urandom % 16);
    for (int k = 0; k < 16; k++) begin
      int ch;
      ch = $urandom % 2;
      move(ch, want_state[ch] + 2'(1 + $urandom % 3), 1'($urandom));
      lv(ch);
    end
    $display("test random_moves done");
    // Found first, then none, so both results move the output
    for (int c = 0; c < 2; c++) begin
      move(c, 2'h2, 1'b1);
      for (int p = 0; p < 2; p++) begin
        @(negedge clk);
        rx_present[c] = 1'(p == 0);
        want_detect[c] = 1'b1;
        wait_ack(c, 20 * tick_divider + 30, n);
        check(c ? detect_result_1 : detect_result_0,
          p ? tpsc_pkg::DET_NONE : tpsc_pkg::DET_FOUND,
          "detect result");
        @(negedge clk);
        want_detect[c] = 1'b0;
        lv(c);
      end
    end
    move(0, 2'h0, 1'b0);
    @(negedge clk);
    want_detect[0] = 1'b1;
    lv(0);
    @(negedge clk);
    want_detect[0] = 1'b0;
    lv(0);
    move(1, 2'h3, 1'b0);
    lv(1);
    $display("test detect_loop_beacon done");
    @(negedge clk);
    ref_input_sleep_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check({ref_input_running, ref_forward_en}, 2'h0, "ref asleep");
    check(pll_running, 1, "pll kept");
    check(pll_lock_flag, 0, "lock dropped");
    @(negedge clk);
    ref_input_sleep_n = 1'b1;
    wait_lock();
    @(negedge clk);
    pll_sleep = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check({pll_running, pll_lock_flag}, 2'h0, "pll asleep");
    check({tx_state_now_0, rx_state_now_1}, 4'hF, "analog off");
    @(negedge clk);
    pll_sleep = 1'b0;
    wait_lock();
    $display("test sleeps done");
    give_verdict();
  end
endmodule

// File: tpsc_lane.sv
// One channel: power-state tracking, transition timing, acknowledge.
// Assumes synchronised inputs and a shared divided tick on clk.
`timescale 1ns/100ps
module tpsc_lane (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [1:0] tx_state,
  input wire logic [1:0] rx_state,
  input wire logic tx_idle_request,
  input wire logic rx_detect_request,
  input wire logic rx_present,
  input wire logic [11:0] leave_deep_count,
  input wire logic [7:0] shallow_transition_count,
  input wire logic [9:0] enter_deep_count,
  output logic phy_ack_pulse,
  output logic [2:0] detect_result,
  output logic [1:0] tx_state_now,
  output logic [1:0] rx_state_now,
  output logic tx_active,
  output logic tx_beacon,
  output logic loopback
);
  logic [1:0] tx_cur_r;
  logic [1:0] tgt_r;
  logic [11:0] cnt_r;
  logic busy_r;
  logic det_busy_r;
  logic det_req_d_r;
  logic [11:0] load_nxt;
  logic pwr_chg;
  // pick the count from the kind of transition
  always_comb begin
    if (tx_cur_r == 2'(tpsc_pkg::TPSC_P2)) begin
      load_nxt = leave_deep_count;
    end else if (tx_state == 2'(tpsc_pkg::TPSC_P2)) begin
      load_nxt = {2'h0, enter_deep_count};
    end else begin
      load_nxt = {4'h0, shallow_transition_count};
    end
  end
  assign pwr_chg = !busy_r && !det_busy_r && (tx_state != tx_cur_r);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cur_r <= tpsc_pkg::PS_RST;
      tgt_r <= tpsc_pkg::PS_RST;
      cnt_r <= 12'h000;
      busy_r <= 1'b0;
      det_busy_r <= 1'b0;
      det_req_d_r <= 1'b0;
      phy_ack_pulse <= 1'b0;
      detect_result <= tpsc_pkg::DET_NONE;
    end else begin
      phy_ack_pulse <= 1'b0;
      det_req_d_r <= rx_detect_request;
      if (pwr_chg || (!busy_r && !det_busy_r && rx_detect_request &&
          !det_req_d_r && tx_cur_r == 2'(tpsc_pkg::TPSC_P1) &&
          tx_idle_request)) begin
        busy_r <= pwr_chg;
        det_busy_r <= !pwr_chg;
        tgt_r <= tx_state;
        cnt_r <= pwr_chg ? load_nxt : 12'h001;
      end else if ((busy_r || det_busy_r) && tick) begin
        if (cnt_r <= 12'h001) begin
          // Ack only when the full count has elapsed
          busy_r <= 1'b0;
          det_busy_r <= 1'b0;
          phy_ack_pulse <= 1'b1;
          if (busy_r) begin
            tx_cur_r <= tgt_r;
          end
          detect_result <= det_busy_r && rx_present ?
            tpsc_pkg::DET_FOUND : tpsc_pkg::DET_NONE;
        end else begin
          cnt_r <= cnt_r - 12'h001;
        end
      end
    end
  end
  // each direction's analog state follows its own input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_now <= tpsc_pkg::PS_RST;
      rx_state_now <= tpsc_pkg::PS_RST;
      tx_active <= 1'b0;
      tx_beacon <= 1'b0;
      loopback <= 1'b0;
    end else begin
      tx_state_now <= tx_cur_r;
      rx_state_now <= rx_state;
      tx_active <= tx_cur_r == 2'(tpsc_pkg::TPSC_P0) &&
        !tx_idle_request && !rx_detect_request;
      loopback <= tx_cur_r == 2'(tpsc_pkg::TPSC_P0) &&
        !tx_idle_request && rx_detect_request;
      tx_beacon <= tx_cur_r == 2'(tpsc_pkg::TPSC_P2) &&
        !tx_idle_request;
    end
  end
  property p_ack_one;
    @(posedge clk) disable iff (!rst_n)
      phy_ack_pulse |=> !phy_ack_pulse;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_tick;
    @(posedge clk) disable iff (!rst_n)
      $rose(phy_ack_pulse) |-> $past(tick);
  endproperty
  a_ack_tick: assert property (p_ack_tick) else $error("ack off tick");
  property p_beacon;
    @(posedge clk) disable iff (!rst_n)
      tx_beacon |-> $past(tx_cur_r) == 2'h3 && !$past(tx_idle_request);
  endproperty
  a_beacon: assert property (p_beacon) else $error("bad beacon");
  property p_loop;
    @(posedge clk) disable iff (!rst_n)
      loopback |-> $past(tx_cur_r) == 2'h0 && $past(rx_detect_request) &&
        !$past(tx_idle_request) && !tx_active;
  endproperty
  a_loop: assert property (p_loop) else $error("loop and tx");
endmodule

// File: tpsc_mac_model.sv
// Behavioural link controller driving one channel's power controls.
// Assumes the bench updates its wishes at the falling clock edge.
`timescale 1ns/100ps
module tpsc_mac_model (
  input wire logic [1:0] want_state,
  input wire logic want_idle,
  input wire logic want_detect,
  output logic [1:0] tx_power_state,
  output logic [1:0] rx_power_state,
  output logic tx_idle_request,
  output logic rx_detect_request
);
  // One code feeds both directions so they never drift apart
  assign tx_power_state = want_state;
  assign rx_power_state = want_state;
  // Shallow sleep states must never leave electrical idle
  assign tx_idle_request = (want_state == tpsc_pkg::TPSC_P0S ||
    want_state == tpsc_pkg::TPSC_P1) ? 1'b1 : want_idle;
  // Detect together with idle in P0 is never offered
  assign rx_detect_request = want_detect &
    ~(want_state == tpsc_pkg::TPSC_P0 && tx_idle_request);
endmodule

// File: tpsc_pkg.sv
// Constants for the transceiver power-state control block.
// Assumes a single 100 MHz clock and no register bus.
package tpsc_pkg;
  typedef enum logic [1:0] {
    TPSC_P0 = 2'b00,
    TPSC_P0S = 2'b01,
    TPSC_P1 = 2'b10,
    TPSC_P2 = 2'b11
  } tpsc_pstate_e;
  localparam int CLK_MHZ = 100;
  localparam int TICK_MHZ = 25;
  // Default divider gives about 25 MHz ticks from the clock
  localparam logic [4:0] TICK_DIV_RST = 5'(CLK_MHZ / TICK_MHZ);
  localparam int LEAVE_W = 12;
  localparam int SHALLOW_W = 8;
  localparam int ENTER_W = 10;
  localparam int DIV_W = 5;
  localparam int CNT_W = 12;
  localparam int LOCK_TICKS = 4;
  localparam logic [2:0] DET_FOUND = 3'h3;
  localparam logic [2:0] DET_NONE = 3'h0;
  localparam logic [1:0] PS_RST = 2'h3;
endpackage

// File: tpsc_top.sv
// Power-state control for a two-channel transceiver tile.
// Assumes control inputs may be asynchronous; all but the three count inputs pass two flops.
`timescale 1ns/100ps
// Operation
// - TX and RX of each channel power down independently.
// - pll_sleep high powers down the PLL and all analog of both lanes.
// - ref_input_sleep_n low stops only the reference input stage.
// - Sleeping reference input is withheld from downstream tiles.
// - Lock flag rises after reference input sleep is released.
// - Lock flag rises after PLL sleep is released.
// - Outside PCIe only codes 00 active and 11 idle are used.
// - P0 transmits data; idle high gives electrical idle.
// - P0 detect high gives loopback; detect with idle not allowed.
// - P1 with detect high runs receiver detection.
// - P2 sends beacon when idle low, else stays idle.
// - Each TX power change acknowledged by a one-cycle pulse per channel.
// - Three counts: leaving P2, entering P2, all others.
// - Counts use ticks of clock divided by tick_divider.
// - Detection ends with ack pulse and result on detect_result.
// - Leave-P2 count is 12 bits.
// - Other-transition count is 8 bits.
// - Enter-P2 count is 10 bits.
module tpsc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pll_sleep,
  input wire logic ref_input_sleep_n,
  input wire logic [1:0] tx_power_state_0,
  input wire logic [1:0] tx_power_state_1,
  input wire logic [1:0] rx_power_state_0,
  input wire logic [1:0] rx_power_state_1,
  input wire logic [1:0] tx_idle_request,
  input wire logic [1:0] rx_detect_request,
  input wire logic [1:0] rx_present,
  input wire logic [11:0] leave_deep_count,
  input wire logic [7:0] shallow_transition_count,
  input wire logic [9:0] enter_deep_count,
  input wire logic [4:0] tick_divider,
  output logic pll_lock_flag,
  output logic pll_running,
  output logic ref_input_running,
  output logic ref_forward_en,
  output logic [1:0] phy_ack_pulse,
  output logic [2:0] detect_result_0,
  output logic [2:0] detect_result_1,
  output logic [1:0] tx_state_now_0,
  output logic [1:0] tx_state_now_1,
  output logic [1:0] rx_state_now_0,
  output logic [1:0] rx_state_now_1,
  output logic [1:0] tx_active,
  output logic [1:0] tx_beacon,
  output logic [1:0] loopback
);
  logic [1:0] rs_r;
  logic srst_n;
  logic [23:0] s1_r;
  logic [23:0] s2_r;
  logic [23:0] raw;
  logic [4:0] div_r;
  logic tick_r;
  logic [3:0] lock_cnt_r;
  logic pll_up;
  logic ref_up;
  logic [2:0] det0;
  logic [2:0] det1;
  logic [1:0] ack;
  logic [1:0] txn0;
  logic [1:0] txn1;
  logic [1:0] rxn0;
  logic [1:0] rxn1;
  logic [1:0] act;
  logic [1:0] bcn;
  logic [1:0] lpb;
  // Idle pin levels, so no false state request follows reset
  localparam logic [23:0] SYNC_RST = {1'b0, 1'b1, {4{tpsc_pkg::PS_RST}},
    2'h3, 2'h0, 2'h0, tpsc_pkg::TICK_DIV_RST, 3'h0};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_r <= 2'h0;
    end else begin
      rs_r <= {rs_r[0], 1'b1};
    end
  end
  assign srst_n = rs_r[1];
  // Every pin input but the three counts passes two flops; no logic reads the first stage
  assign raw = {pll_sleep, ref_input_sleep_n, tx_power_state_0,
    tx_power_state_1, rx_power_state_0, rx_power_state_1,
    tx_idle_request, rx_detect_request, rx_present,
    tick_divider, 3'h0};
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end
  // Tick divider; a zero divider is treated as one
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      div_r <= 5'h00;
      tick_r <= 1'b0;
    end else if (div_r + 5'h01 >= s2_r[7:3] || s2_r[7:3] == 5'h00) begin
      div_r <= 5'h00;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 5'h01;
      tick_r <= 1'b0;
    end
  end
  assign pll_up = !s2_r[23];
  assign ref_up = s2_r[22];
  // Lock waits a few ticks after both sleeps are released
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      lock_cnt_r <= 4'h0;
      pll_lock_flag <= 1'b0;
      pll_running <= 1'b0;
      ref_input_running <= 1'b0;
      ref_forward_en <= 1'b0;
    end else begin
      pll_running <= pll_up;
      ref_input_running <= ref_up;
      ref_forward_en <= ref_up;
      if (!pll_up || !ref_up) begin
        lock_cnt_r <= 4'h0;
        pll_lock_flag <= 1'b0;
      end else if (lock_cnt_r != 4'(tpsc_pkg::LOCK_TICKS)) begin
        lock_cnt_r <= lock_cnt_r + (tick_r ? 4'h1 : 4'h0);
      end else begin
        pll_lock_flag <= 1'b1;
      end
    end
  end
  tpsc_lane u_lane0 (
    .clk(clk), .rst_n(srst_n), .tick(tick_r),
    .tx_state(s2_r[21:20]), .rx_state(s2_r[17:16]),
    .tx_idle_request(s2_r[12]), .rx_detect_request(s2_r[10]),
    .rx_present(s2_r[8]), .leave_deep_count(leave_deep_count),
    .shallow_transition_count(shallow_transition_count),
    .enter_deep_count(enter_deep_count), .phy_ack_pulse(ack[0]),
    .detect_result(det0), .tx_state_now(txn0), .rx_state_now(rxn0),
    .tx_active(act[0]), .tx_beacon(bcn[0]), .loopback(lpb[0])
  );
  tpsc_lane u_lane1 (
    .clk(clk), .rst_n(srst_n), .tick(tick_r),
    .tx_state(s2_r[19:18]), .rx_state(s2_r[15:14]),
    .tx_idle_request(s2_r[13]), .rx_detect_request(s2_r[11]),
    .rx_present(s2_r[9]), .leave_deep_count(leave_deep_count),
    .shallow_transition_count(shallow_transition_count),
    .enter_deep_count(enter_deep_count), .phy_ack_pulse(ack[1]),
    .detect_result(det1), .tx_state_now(txn1), .rx_state_now(rxn1),
    .tx_active(act[1]), .tx_beacon(bcn[1]), .loopback(lpb[1])
  );
  // Lane outputs are flopped again; all but ack and detect result gated by PLL sleep
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      phy_ack_pulse <= 2'h0;
      detect_result_0 <= tpsc_pkg::DET_NONE;
      detect_result_1 <= tpsc_pkg::DET_NONE;
      tx_state_now_0 <= tpsc_pkg::PS_RST;
      tx_state_now_1 <= tpsc_pkg::PS_RST;
      rx_state_now_0 <= tpsc_pkg::PS_RST;
      rx_state_now_1 <= tpsc_pkg::PS_RST;
      tx_active <= 2'h0;
      tx_beacon <= 2'h0;
      loopback <= 2'h0;
    end else begin
      phy_ack_pulse <= ack;
      detect_result_0 <= det0;
      detect_result_1 <= det1;
      tx_state_now_0 <= pll_up ? txn0 : tpsc_pkg::PS_RST;
      tx_state_now_1 <= pll_up ? txn1 : tpsc_pkg::PS_RST;
      rx_state_now_0 <= pll_up ? rxn0 : tpsc_pkg::PS_RST;
      rx_state_now_1 <= pll_up ? rxn1 : tpsc_pkg::PS_RST;
      tx_active <= pll_up ? act : 2'h0;
      tx_beacon <= pll_up ? bcn : 2'h0;
      loopback <= pll_up ? lpb : 2'h0;
    end
  end
  property p_lock_drop;
    @(posedge clk) disable iff (!srst_n)
      !pll_up |=> !pll_lock_flag;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock in sleep");
  property p_fwd;
    @(posedge clk) disable iff (!srst_n)
      !ref_up |=> !ref_forward_en;
  endproperty
  a_fwd: assert property (p_fwd) else $error("ref forwarded");
  property p_pll_off;
    @(posedge clk) disable iff (!srst_n)
      !pll_up |=> tx_active == 2'h0 && tx_beacon == 2'h0;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("lane on in sleep");
  property p_ref_only;
    @(posedge clk) disable iff (!srst_n)
      pll_up && !ref_up |=> pll_running;
  endproperty
  a_ref_only: assert property (p_ref_only) else $error("pll stopped");
endmodule
